// ===== core/dcff_flag_core.sv
`timescale 1ns/100ps
`default_nettype none
module dcff_flag_core (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    arst_n,
    // Register bus
    input  wire dcff_pkg::dcff_apb_req_t apb_req,
    output var  dcff_pkg::dcff_apb_rsp_t apb_rsp,
    // Writer side
    input  wire logic                    wr_tick,
    input  wire logic                    wr_en,
    input  wire logic [17:0]             wr_data,
    // Reader side
    input  wire logic                    rd_tick,
    input  wire logic                    rd_en,
    input  wire logic                    oe_n,
    output logic      [17:0]             rd_data,
    output logic                         rd_data_oe_n,
    // Status
    output var  dcff_pkg::dcff_flags_t   flags,
    output logic                         irq
);
    import dcff_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    // Word memory, no reset needed
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    dcff_state_t s;       // Registered state
    dcff_state_t next_s;  // Next state

    // Handshake terms
    // Both sides stay live in recovery: writes go on, reads are
    // held so the rewound pointer is never passed
    logic        wr_acc;   // Word accepted
    logic        rd_acc;   // Word taken
    logic        setup;    // APB setup cycle
    logic        access;   // APB completing
    logic        bus_wr;   // Write completes
    logic        rt_req;   // Retransmit command
    logic [PTR_W-1:0] next_wptr;
    logic [PTR_W-1:0] next_rptr;
    logic [PTR_W-1:0] cnt_w;   // Fill seen by writer
    logic [PTR_W-1:0] cnt_r;   // Fill seen by reader
    logic [PTR_W-1:0] cnt_a;   // Live fill
    logic [EV_W-1:0]  ev;      // Events this cycle
    logic [EV_W-1:0]  clr;     // Write-one clears
    logic [31:0]      rd_word; // Register read value

    // ****************************************
    // Helpers
    // ****************************************
    // Words held between two pointers
    // The wrap bit above the address tells a full store from an
    // empty one, so the difference is exact
    function automatic logic [PTR_W-1:0] fill(
        input logic [PTR_W-1:0] w,
        input logic [PTR_W-1:0] r
    );
        fill = w - r;
    endfunction : fill

    // Almost-empty flag, active low
    // Low from n-1 words down, so the read that leaves n-1
    // words behind is the one that pulls it low
    function automatic logic ae_n(
        input logic [PTR_W-1:0]  c,
        input logic [ADDR_W-1:0] n
    );
        ae_n = !(c < {1'b0, n});
    endfunction : ae_n

    // Almost-full flag, active low
    // Low from depth-m words up: the write after depth-(m+1)
    // words is the one that pulls it low
    function automatic logic af_n(
        input logic [PTR_W-1:0]  c,
        input logic [ADDR_W-1:0] m
    );
        af_n = !(c >= DEPTH_WORDS - {1'b0, m});
    endfunction : af_n

    // Register read decode
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == REG_CTRL) || (a == REG_AE_OFF) ||
                 (a == REG_AF_OFF) || (a == REG_STATUS) ||
                 (a == REG_INT_STS) || (a == REG_INT_MASK);
    endfunction : mapped

    // ****************************************
    // Memory write
    // ****************************************
    // Write only while not full
    // No read-during-write bypass: a word is readable only once
    // the copied write pointer covers it, two cycles at least,
    // which keeps the read path a plain array lookup
    always_ff @(posedge clk_sys) begin
        if (wr_acc) begin
            mem[s.wptr[ADDR_W-1:0]] <= wr_data;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    // One process computes every next value; the single state
    // register below holds them all
    always_comb begin
        next_s = s;

        // Handshakes on the domain ticks
        wr_acc = wr_tick && wr_en && s.flags.full_flag_n;
        rd_acc = rd_tick && rd_en && s.flags.empty_flag_n
                 && (s.rt_state == RT_IDLE);
        next_wptr = s.wptr + PTR_W'(wr_acc);
        next_rptr = s.rptr + PTR_W'(rd_acc);

        // Bus phases
        // The answer is registered in the setup cycle: every bus output
        // comes straight from a flip-flop at no cost of a wait state
        setup  = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable && s.rsp.pready;
        bus_wr = access && apb_req.pwrite;
        rt_req = bus_wr && (apb_req.paddr == REG_CTRL)
                 && apb_req.pwdata[CTRL_RT_BIT];
        clr = '0;
        if (bus_wr && (apb_req.paddr == REG_INT_STS)) begin
            clr = apb_req.pwdata[EV_W-1:0];
        end

        // Register writes
        // New offsets take effect on the next flag update; in sync
        // mode that is the next tick of the flag's own side
        if (bus_wr) begin
            unique case (apb_req.paddr)
                REG_CTRL: begin
                    next_s.sync_flag_select =
                        apb_req.pwdata[CTRL_SYNC_SEL_BIT];
                end
                REG_AE_OFF: begin
                    next_s.ae_off = apb_req.pwdata[ADDR_W-1:0];
                end
                REG_AF_OFF: begin
                    next_s.af_off = apb_req.pwdata[ADDR_W-1:0];
                end
                REG_INT_MASK: begin
                    next_s.int_mask = apb_req.pwdata[EV_W-1:0];
                end
                default: begin
                    // Status is read only
                end
            endcase
        end

        // Read data, low until first read
        // Loaded only on an accepted read, so the last word holds
        // while the store is empty or recovering
        if (rd_acc) begin
            next_s.rd_data = mem[s.rptr[ADDR_W-1:0]];
        end
        // Enable pin copied each cycle
        next_s.rd_data_oe_n = oe_n;

        // Pointers
        // Plain binary is safe here: one clock, so the copies
        // below need no gray code
        next_s.wptr = next_wptr;
        next_s.rptr = next_rptr;

        // Retransmit rewinds the reader; the writer is untouched,
        // so both ticks may keep running meanwhile
        // A second command during recovery is ignored; software
        // should wait for the recovery-done event
        unique case (s.rt_state)
            RT_IDLE: begin
                if (rt_req) begin
                    next_s.rptr     = '0;
                    next_s.rt_state = RT_RECOVER;
                    next_s.rt_cnt   = RT_CNT_W'(RTR_CYCLES - 1);
                end
            end
            RT_RECOVER: begin
                // Reads held off until recovery ends
                if (s.rt_cnt == '0) begin
                    next_s.rt_state = RT_IDLE;
                end else begin
                    next_s.rt_cnt = s.rt_cnt - 1'b1;
                end
            end
            default: begin
                next_s.rt_state = RT_IDLE;
            end
        endcase

        // Writer side: the read pointer is copied every cycle, so
        // full is judged against a pointer one cycle old. A read in
        // the write tick's own cycle or the one before frees its space only on
        // the next tick; an earlier read is seen at once.
        // An old copy can only overstate the fill, so no unread
        // word is ever overwritten.
        next_s.rptr_cp = s.rptr;
        cnt_w = fill(next_wptr, s.rptr_cp);
        if (wr_tick) begin
            // Full moves on write ticks only
            next_s.flags.full_flag_n =
                (cnt_w != DEPTH_WORDS);
        end

        // Reader side, same scheme with the write pointer. A word
        // written two cycles or more before a read tick clears empty
        // on it; a later one waits a tick, so the first word takes
        // one or two read periods.
        // An old copy can only understate the fill, so a read never
        // passes the writer.
        next_s.wptr_cp = s.wptr;
        cnt_r = fill(s.wptr_cp, next_s.rptr);
        if (rd_tick) begin
            // Empty moves on read ticks only
            next_s.flags.empty_flag_n =
                (cnt_r != '0);
        end

        // Programmable flags
        // Async mode reads the live fill, which may move on any
        // system cycle; a user that needs them steady between its
        // own clock edges should pick sync mode
        cnt_a = fill(next_wptr, next_s.rptr);
        if (!s.sync_flag_select) begin
            // Registered to their ticks; skipped in recovery so the
            // first tick after it shows the rewound pointer
            if (rd_tick && (s.rt_state == RT_IDLE)) begin
                next_s.flags.almost_empty_flag_n =
                    ae_n(cnt_r, s.ae_off);
            end
            if (wr_tick && (s.rt_state == RT_IDLE)) begin
                next_s.flags.almost_full_flag_n =
                    af_n(cnt_w, s.af_off);
            end
        end else begin
            // Asynchronous timing: follow live pointers every cycle
            next_s.flags.almost_empty_flag_n =
                ae_n(cnt_a, s.ae_off);
            next_s.flags.almost_full_flag_n =
                af_n(cnt_a, s.af_off);
        end

        // Events on flag assertion and recovery end
        // Edges only, so a flag that stays asserted raises one
        // event, not one per cycle
        ev = '0;
        ev[EV_EMPTY]  = s.flags.empty_flag_n
                        && !next_s.flags.empty_flag_n;
        ev[EV_FULL]   = s.flags.full_flag_n
                        && !next_s.flags.full_flag_n;
        ev[EV_AEMPTY] = s.flags.almost_empty_flag_n
                        && !next_s.flags.almost_empty_flag_n;
        ev[EV_AFULL]  = s.flags.almost_full_flag_n
                        && !next_s.flags.almost_full_flag_n;
        ev[EV_RT_DONE] = (s.rt_state == RT_RECOVER)
                         && (s.rt_cnt == '0);

        // Set wins over a clear in the same cycle
        next_s.int_sts = (s.int_sts & ~clr) | ev;
        next_s.irq     = |(next_s.int_sts & next_s.int_mask);

        // Read mux, reserved bits zero
        // Taken in the setup cycle, so a status read shows the
        // state one cycle before its answer stands
        rd_word = '0;
        unique case (apb_req.paddr)
            REG_CTRL: begin
                rd_word[CTRL_SYNC_SEL_BIT] = s.sync_flag_select;
            end
            REG_AE_OFF: begin
                rd_word[ADDR_W-1:0] = s.ae_off;
            end
            REG_AF_OFF: begin
                rd_word[ADDR_W-1:0] = s.af_off;
            end
            REG_STATUS: begin
                rd_word[3:0] = s.flags;
                rd_word[STS_RT_BUSY_BIT] = (s.rt_state == RT_RECOVER);
                rd_word[STS_CNT_LSB +: PTR_W] = fill(s.wptr, s.rptr);
            end
            REG_INT_STS: begin
                rd_word[EV_W-1:0] = s.int_sts;
            end
            REG_INT_MASK: begin
                rd_word[EV_W-1:0] = s.int_mask;
            end
            default: begin
                // Unmapped reads zero
            end
        endcase

        // No wait state: answer in the first access cycle
        next_s.rsp.pready  = setup;
        next_s.rsp.pslverr = setup && !mapped(apb_req.paddr);
        if (setup) begin
            next_s.rsp.prdata = rd_word;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Async reset to constants only; ticks may keep arriving
    // Empty and almost empty asserted, full and almost full clear,
    // data released until the first cycle copies the enable pin;
    // the word array is left alone, nothing reads it unwritten
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            next_reset : begin
                s.wptr  <= '0;
                s.rptr  <= '0;
                s.rptr_cp <= '0;
                s.wptr_cp <= '0;
                s.flags.full_flag_n         <= 1'b1;
                s.flags.empty_flag_n        <= 1'b0;
                s.flags.almost_empty_flag_n <= 1'b0;
                s.flags.almost_full_flag_n  <= 1'b1;
                s.rd_data      <= '0;
                s.rd_data_oe_n <= 1'b1;
                s.rt_state     <= RT_IDLE;
                s.rt_cnt       <= '0;
                s.sync_flag_select <= CTRL_SYNC_SEL_RST;
                s.ae_off   <= AE_OFF_RST;
                s.af_off   <= AF_OFF_RST;
                s.int_sts  <= '0;
                s.int_mask <= '0;
                s.irq      <= 1'b0;
                s.rsp      <= '0;
            end
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // Outputs, all from flip-flops
    // ****************************************
    // Flags are registered levels: full, empty and the sync-mode almost flags settle
    // one system cycle after the tick that moves them; async almost flags track the live fill
    assign apb_rsp      = s.rsp;
    assign rd_data      = s.rd_data;
    assign rd_data_oe_n = s.rd_data_oe_n;
    assign flags        = s.flags;
    assign irq          = s.irq;
endmodule : dcff_flag_core
`default_nettype wire

// ===== shared/dcff_pkg.sv
`default_nettype none
package dcff_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int DATA_W = 18;           // Word width
    localparam int ADDR_W = 13;           // 8192 words
    localparam int PTR_W  = ADDR_W + 1;   // Pointer with wrap bit
    localparam logic [PTR_W-1:0] DEPTH_WORDS = 14'h2000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;  // clk_sys at 250 MHz
    localparam int RTR_NS        = 90;    // retransmit_recovery_time
    // Least time, rounded up to whole cycles
    localparam int RTR_CYCLES =
        (RTR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RT_CNT_W = 5;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_AE_OFF   = 8'h04;
    localparam logic [7:0] REG_AF_OFF   = 8'h08;
    localparam logic [7:0] REG_STATUS   = 8'h0c;
    localparam logic [7:0] REG_INT_STS  = 8'h10;
    localparam logic [7:0] REG_INT_MASK = 8'h14;

    // Control fields and reset values
    localparam int CTRL_SYNC_SEL_BIT = 0;  // sync_flag_select
    localparam int CTRL_RT_BIT       = 1;  // Retransmit, write one
    localparam logic CTRL_SYNC_SEL_RST = 1'b1;
    localparam logic [ADDR_W-1:0] AE_OFF_RST = 13'h0007;
    localparam logic [ADDR_W-1:0] AF_OFF_RST = 13'h0007;

    // Status fields
    localparam int STS_RT_BUSY_BIT = 4;
    localparam int STS_CNT_LSB     = 8;

    // Interrupt event bits
    localparam int EV_EMPTY   = 0;
    localparam int EV_FULL    = 1;
    localparam int EV_AEMPTY  = 2;
    localparam int EV_AFULL   = 3;
    localparam int EV_RT_DONE = 4;
    localparam int EV_W       = 5;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        RT_IDLE    = 2'b01,
        RT_RECOVER = 2'b10
    } dcff_rt_t;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } dcff_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dcff_apb_rsp_t;

    typedef struct packed {
        logic full_flag_n;
        logic empty_flag_n;
        logic almost_empty_flag_n;
        logic almost_full_flag_n;
    } dcff_flags_t;

    typedef struct packed {
        logic [PTR_W-1:0]    wptr;      // Write pointer
        logic [PTR_W-1:0]    rptr;      // Read pointer
        logic [PTR_W-1:0]    rptr_cp;   // Read ptr seen by writer
        logic [PTR_W-1:0]    wptr_cp;   // Write ptr seen by reader
        dcff_flags_t         flags;
        logic [DATA_W-1:0]   rd_data;
        logic                rd_data_oe_n;
        dcff_rt_t            rt_state;
        logic [RT_CNT_W-1:0] rt_cnt;
        logic                sync_flag_select;
        logic [ADDR_W-1:0]   ae_off;
        logic [ADDR_W-1:0]   af_off;
        logic [EV_W-1:0]     int_sts;
        logic [EV_W-1:0]     int_mask;
        logic                irq;
        dcff_apb_rsp_t       rsp;
    } dcff_state_t;
endpackage : dcff_pkg
`default_nettype wire

// ===== tb/dcff_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dcff_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register bus
    input wire dcff_pkg::dcff_apb_req_t apb_req,
    input wire dcff_pkg::dcff_apb_rsp_t apb_rsp,
    // Streams
    input wire logic wr_tick,
    input wire logic rd_tick,
    input wire logic rd_en,
    input wire logic oe_n,
    input wire logic [17:0] rd_data,
    input wire logic rd_data_oe_n,
    input wire dcff_pkg::dcff_flags_t flags
);
    import dcff_pkg::*;
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Setup phase of a bus transfer
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    // Read strobe met while empty
    sequence s_dead_read;
        rd_tick && rd_en && !flags.empty_flag_n;
    endsequence
    a_rst_flags: assert property ($rose(arst_n) |-> flags == 4'h9 && rd_data == 18'h0)
        else $error("flags or data wrong after reset");
    a_oe_track: assert property (1'b1 |=> rd_data_oe_n == $past(oe_n))
        else $error("output enable not followed");
    a_rd_hold: assert property (!(rd_tick && rd_en) |=> $stable(rd_data))
        else $error("read word moved without a read");
    a_empty_refuse: assert property (s_dead_read |=> $stable(rd_data))
        else $error("read taken while empty");
    a_full_on_tick: assert property ($changed(flags.full_flag_n) |-> $past(wr_tick))
        else $error("full flag moved off a write tick");
    a_empty_on_tick: assert property ($changed(flags.empty_flag_n) |-> $past(rd_tick))
        else $error("empty flag moved off a read tick");
    a_ready_next: assert property (s_setup |=> apb_rsp.pready)
        else $error("no ready in access cycle");
    a_ready_one: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held two cycles");
    a_afull_with_full: assert property ($fell(flags.full_flag_n) |-> !flags.almost_full_flag_n)
        else $error("full without almost full");
    a_aempty_with_empty: assert property ($fell(flags.empty_flag_n) |-> !flags.almost_empty_flag_n)
        else $error("empty without almost empty");
endmodule : dcff_monitor
bind dcff_flag_core dcff_monitor u_mon (.clk_sys(clk_sys), .arst_n(arst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .wr_tick(wr_tick), .rd_tick(rd_tick), .rd_en(rd_en), .oe_n(oe_n),
    .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n), .flags(flags));
`default_nettype wire

// ===== tb/dcff_peer.sv
`timescale 1ns/100ps
`default_nettype none
module dcff_peer #(
    parameter int WR_DIV = 3,
    parameter int RD_DIV = 2
) (
    // Clock
    input wire logic clk_sys,
    // Side clocks as ticks
    output logic wr_tick,
    output logic rd_tick,
    // Read bus
    input wire logic [17:0] rd_data,
    input wire logic rd_data_oe_n,
    output logic [17:0] rd_bus
);
    // ****************************************
    // Free running side clocks
    // ****************************************
    int wc = 0;
    int rc = 0;
    // Never stopped, not even in reset
    always @(posedge clk_sys) begin
        wc <= (wc + 1) % WR_DIV;
        rc <= (rc + 1) % RD_DIV;
    end
    assign wr_tick = (wc == 0);
    assign rd_tick = (rc == 0);
    // No pull on the bus: a released bus shows the inverse word
    assign rd_bus = rd_data_oe_n ? ~rd_data : rd_data;
endmodule : dcff_peer
`default_nettype wire

// ===== tb/dcff_flag_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module dcff_flag_core_tb;
    import dcff_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    dcff_apb_req_t req = '0;
    dcff_apb_rsp_t rsp;
    logic wr_tick, rd_tick, rd_data_oe_n, irq, e;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic oe_n = 1'b0;
    logic [17:0] wr_data = 18'h0;
    logic [17:0] rd_data, rd_bus, ew;
    dcff_flags_t flags;
    logic [17:0] exp_q[$];         // Words still to come out
    logic [17:0] hist[$];          // Everything since reset
    logic [31:0] q;
    logic [7:0] ra[5] = '{REG_CTRL, REG_AE_OFF, REG_AF_OFF, REG_INT_MASK, 8'h18};
    logic [31:0] rv[5] = '{32'h1, 32'h7, 32'h7, 32'h0, 32'h0};
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 32'h7e5d;
    int fill, k, c;
    always #2 clk_sys = ~clk_sys;
    dcff_flag_core u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
        .wr_tick(wr_tick), .wr_en(wr_en), .wr_data(wr_data), .rd_tick(rd_tick), .rd_en(rd_en),
        .oe_n(oe_n), .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n), .flags(flags), .irq(irq));
    dcff_peer u_peer (.clk_sys(clk_sys), .wr_tick(wr_tick), .rd_tick(rd_tick),
        .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n), .rd_bus(rd_bus));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task automatic tmo();
        n_errors++;
        $display("[ERR] wait_limit exp 0 got 1");
        print_verdict();
    endtask : tmo
    task automatic do_reset();
        arst_n <= 1'b0;
        exp_q.delete();
        hist.delete();
        repeat (12) @(posedge clk_sys);
        `CHK("rst flags", 4'h9, flags)
        `CHK("rst data", 18'h0, rd_data)
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask : do_reset
    // One transfer; idle cycle after so psel never flips twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk_sys);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp.pready !== 1'b1 && n < 40);
        if (n >= 40) tmo();
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    // Write enable is left high; caller drops it
    task automatic put(input logic [17:0] d);
        int n;
        wr_en <= 1'b1;
        wr_data <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!(wr_tick === 1'b1 && flags.full_flag_n === 1'b1) && n < 50);
        if (n >= 50) tmo();
        exp_q.push_back(d);
        hist.push_back(d);
    endtask : put
    task automatic drain(input int keep);
        int n;
        rd_en <= 1'b1;
        for (n = 0; n < 20000 && exp_q.size() > keep; n++) @(posedge clk_sys);
        rd_en <= 1'b0;
        if (n >= 20000) tmo();
    endtask : drain
    // Watch every accepted read against the oldest note
    always @(posedge clk_sys) begin
        if (arst_n && rd_tick && rd_en && flags.empty_flag_n === 1'b1) begin
            #1;
            if (exp_q.size() == 0) `CHK("extra read", 1'b0, 1'b1)
            else begin
                ew = exp_q.pop_front();
                `CHK("rd_data", ew, rd_data)
            end
        end
    end
    initial begin
        #360000;
        tmo();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        do_reset();
        `CHK("bus low", 18'h0, rd_bus)
        oe_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK("oe", 1'b1, rd_data_oe_n)
        oe_n <= 1'b0;
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0);
            `CHK("reg", rv[i], q)
        end
        `CHK("slverr", 1'b1, e)
        // Fill to full, thresholds at every level
        for (fill = 1; fill <= 8192; fill++) begin
            put(18'($random(seed)));
            repeat (2) @(posedge clk_sys);
            `CHK("afull", fill < int'(DEPTH_WORDS) - 7, flags.almost_full_flag_n)
            `CHK("aempty", fill >= 7, flags.almost_empty_flag_n)
        end
        `CHK("full", 1'b0, flags.full_flag_n)
        wr_data <= 18'h3ffff;
        repeat (7) @(posedge clk_sys);
        wr_en <= 1'b0;
        drain(0);
        repeat (8) @(posedge clk_sys);
        `CHK("empty", 1'b0, flags.empty_flag_n)
        // First word into an empty store
        put(18'h2a5a5);
        wr_en <= 1'b0;
        k = 0;
        for (c = 0; c < 30 && flags.empty_flag_n !== 1'b1; c++) begin
            @(posedge clk_sys);
            k += int'(rd_tick);
        end
        `CHK("latency", 1'b1, k <= 2 && c < 30)
        drain(0);
        // Retransmit with clocks running, sync flag mode
        do_reset();
        apb(1'b1, REG_INT_MASK, 32'h10);
        repeat (10) put(18'($random(seed)));
        wr_en <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h0);  // Sync flag mode from here on
        drain(6);
        `CHK("aempty6", 1'b0, flags.almost_empty_flag_n)
        apb(1'b1, REG_CTRL, 32'h2);
        exp_q = hist;
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("busy", 1'b1, q[STS_RT_BUSY_BIT])
        for (k = 0; k < 60 && q[STS_RT_BUSY_BIT] !== 1'b0; k++) apb(1'b0, REG_STATUS, 32'h0);
        repeat (4) @(posedge clk_sys);
        `CHK("rt flags", 2'b11, {flags.empty_flag_n, flags.almost_empty_flag_n})
        `CHK("irq", 1'b1, irq)
        apb(1'b1, REG_INT_STS, 32'h10);
        repeat (2) @(posedge clk_sys);
        `CHK("irq clr", 1'b0, irq)
        drain(0);
        `CHK("rt words", 0, exp_q.size())
        print_verdict();
    end
endmodule : dcff_flag_core_tb
`default_nettype wire
